// *** rtl/amd_mute_delay.sv ***
// Purpose: Audio delay line, mute controller, ramped mute and control registers.
// Assumes: Sample data and packet info are stable for a whole sample period around
//          the rising edge of sampleClk.
// Notes:   The master clock itself is made by the audio PLL from the ratio output.
`timescale 1ns/1ns
`include "amd_params.svh"
module amd_mute_delay
   import amd_pkg::*;
#(
   parameter int MS_CYCLES = `AMD_MS_CYCLES
) (
   input  wire logic        mclk,                    // Register clock, 25 MHz.
   input  wire logic        reset,                   // Asynchronous reset, active high.
   input  wire logic        psel,                    // APB select.
   input  wire logic        penable,                 // APB enable.
   input  wire logic        pwrite,                  // APB direction.
   input  wire logic [9:0]  paddr,                   // APB byte address.
   input  wire logic [31:0] pwdata,                  // APB write data.
   output logic      [31:0] prdata,                  // APB read data.
   output logic             pready,                  // APB ready, no wait states.
   output logic             pslverr,                 // APB error on unmapped address.
   input  wire logic        sampleClk,               // Audio sample clock, one edge per sample.
   input  wire amd_sample_s sampleIn,                // Incoming stereo sample.
   input  wire amd_pkt_s    pktInfo,                 // Packet kind of the incoming sample.
   input  wire logic [7:0]  muteEvents,              // Raw mute condition levels.
   output amd_sample_s      sampleOut,               // Conditioned stereo sample.
   output logic             sampleOutValid,          // One-cycle pulse per output sample.
   output logic             muteOut,                 // Mute request level.
   output logic             coastOut,                // Coast request to the audio PLL.
   output logic      [9:0]  audioMasterClockOutRatio // Master clock multiple of fs.
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic        sclkMeta_r, sclkSync_r, sclkPrev_r, strobe, strobeD_r;
   logic [7:0]  evMeta_r, evSync_r;
   logic [2:0]  mult_r;
   logic        manSel_r, bypassBit_r, force_r, noAuto_r;
   logic [4:0]  speed_r;
   logic [2:0]  wait_r;
   logic [7:0]  mask_r;
   logic        layoutRaw_r, multiFlag_r;
   logic        muteReq_r, condActive, expired;
   logic [15:0] msPre_r;
   logic [9:0]  msCnt_r, waitMs;
   amd_ramp_e   ramp_r;
   logic [5:0]  step_r;
   logic [4:0]  spdCnt_r, speedEff;
   logic        tick, bypassEff_r, wrEn;
   logic [47:0] dlMem [0:`AMD_DL_DEPTH-1];
   logic [8:0]  dlPtr_r;
   amd_sample_s dlData_r, direct_r, src;
   amd_pkt_s    pkt_r;
   logic        addrOk;
   logic [31:0] rdVal;

   // ----------------------------------------------------------------
   // Crossing from the sample clock and the event pins
   // ----------------------------------------------------------------
   // Two flops before any logic; the edge detector reads the second and a third flop behind it.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sclkMeta_r <= 1'b0;
         sclkSync_r <= 1'b0;
         sclkPrev_r <= 1'b0;
         evMeta_r   <= 8'h00;
         evSync_r   <= 8'h00;
         strobeD_r  <= 1'b0;
      end else begin
         sclkMeta_r <= sampleClk;
         sclkSync_r <= sclkMeta_r;
         sclkPrev_r <= sclkSync_r;
         evMeta_r   <= muteEvents;
         evSync_r   <= evMeta_r;
         strobeD_r  <= strobe;
      end
   end
   assign strobe = sclkSync_r & ~sclkPrev_r;

   // ----------------------------------------------------------------
   // APB register file
   // ----------------------------------------------------------------
   assign pready = 1'b1;
   assign wrEn   = psel & penable & pwrite;

   // Control fields; an invalid clock multiple is dropped so the PLL never sees it.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         mult_r      <= `AMD_RST_MULT;
         manSel_r    <= 1'b0;
         bypassBit_r <= 1'b0;
         speed_r     <= `AMD_RST_SPEED;
         force_r     <= 1'b0;
         wait_r      <= 3'h0;
         noAuto_r    <= 1'b0;
         mask_r      <= `AMD_RST_MASK;
      end else if (wrEn) begin
         case (paddr)
            `AMD_ADDR_MCLK: begin
               if (pwdata[2:0] <= `AMD_MAX_MULT) mult_r <= pwdata[2:0];
            end
            `AMD_ADDR_DELAY: begin
               manSel_r    <= pwdata[`AMD_BIT_MANSEL];
               bypassBit_r <= pwdata[`AMD_BIT_BYPASS];
               speed_r     <= pwdata[4:0];
            end
            `AMD_ADDR_MUTE: begin
               force_r  <= pwdata[`AMD_BIT_FORCE];
               wait_r   <= pwdata[3:1];
               noAuto_r <= pwdata[`AMD_BIT_NOAUTO];
            end
            `AMD_ADDR_MASK: mask_r <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Read value; unused bits read as zero.
   always_comb begin
      rdVal  = 32'h0000_0000;
      addrOk = 1'b1;
      case (paddr)
         `AMD_ADDR_CHMODE: rdVal[`AMD_BIT_MULTI] = multiFlag_r;
         `AMD_ADDR_DELAY:  rdVal[7:0] = {manSel_r, bypassBit_r, 1'b0, speed_r};
         `AMD_ADDR_MASK:   rdVal[7:0] = mask_r;
         `AMD_ADDR_MUTE:   rdVal[4:0] = {force_r, wait_r, noAuto_r};
         `AMD_ADDR_STATUS: begin
            rdVal[`AMD_BIT_LAYOUT]  = layoutRaw_r;
            rdVal[`AMD_BIT_INTMUTE] = muteReq_r;
         end
         `AMD_ADDR_MCLK:   rdVal[2:0] = mult_r;
         default:          addrOk = 1'b0;
      endcase
   end

   // Read data and error are caught in the setup cycle so they come from flops.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel & ~penable) begin
         prdata  <= pwrite ? 32'h0000_0000 : rdVal;
         pslverr <= ~addrOk;
      end
   end

   // ----------------------------------------------------------------
   // Master clock ratio and packet status
   // ----------------------------------------------------------------
   // The PLL multiplies fs by this ratio; a 25 MHz clock cannot make it directly.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) audioMasterClockOutRatio <= 10'd0;
      else audioMasterClockOutRatio <= ({7'd0, mult_r} + 10'd1) * `AMD_MCLK_BASE;
   end

   // Status is refreshed only by packet kinds for which it has a meaning.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         layoutRaw_r <= 1'b0;
         multiFlag_r <= 1'b0;
      end else if (strobe) begin
         if (pktInfo.kind == AMD_PKT_SAMPLE || pktInfo.kind == AMD_PKT_ONEBIT) begin
            layoutRaw_r <= ~pktInfo.layout;
         end
         if (pktInfo.kind == AMD_PKT_SAMPLE) begin
            multiFlag_r <= ~pktInfo.layout & ~pktInfo.compressed;
         end
      end
   end

   // ----------------------------------------------------------------
   // Mute controller
   // ----------------------------------------------------------------
   assign condActive = |(evSync_r & mask_r);
   assign coastOut   = condActive;
   assign muteOut    = muteReq_r;

   // Unmute delay in milliseconds.
   always_comb begin
      case (wait_r)
         3'h1:    waitMs = `AMD_WAIT_MS_1;
         3'h2:    waitMs = `AMD_WAIT_MS_2;
         3'h3:    waitMs = `AMD_WAIT_MS_3;
         3'h4:    waitMs = `AMD_WAIT_MS_4;
         3'h5:    waitMs = `AMD_WAIT_MS_5;
         3'h6:    waitMs = `AMD_WAIT_MS_6;
         3'h7:    waitMs = `AMD_WAIT_MS_7;
         default: waitMs = 10'd0;
      endcase
   end
   assign expired = (waitMs == 10'd0) || (msCnt_r >= waitMs);

   // Counter restarts while any condition or force holds, then runs.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         msPre_r <= 16'd0;
         msCnt_r <= 10'd0;
      end else if (condActive | force_r) begin
         msPre_r <= 16'd0;
         msCnt_r <= 10'd0;
      end else if (!expired) begin
         if (msPre_r == 16'(MS_CYCLES - 1)) begin
            msPre_r <= 16'd0;
            msCnt_r <= msCnt_r + 10'd1;
         end else begin
            msPre_r <= msPre_r + 16'd1;
         end
      end
   end

   // Mute wins; a disabled auto unmute holds the mute until software clears it.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) muteReq_r <= 1'b0;
      else if (condActive | force_r) muteReq_r <= 1'b1;
      else if (!noAuto_r && expired) muteReq_r <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Ramp state and attenuation step
   // ----------------------------------------------------------------
   assign speedEff = (speed_r == 5'd0) ? 5'd1 : speed_r;
   assign tick     = (spdCnt_r >= speedEff - 5'd1);

   // Each state change is taken at a sample edge so the ramp is sample-locked.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) ramp_r <= AMD_UNMUTED;
      else if (strobe) begin
         case (ramp_r)
            AMD_UNMUTED: if (muteReq_r) ramp_r <= AMD_DOWN;
            AMD_DOWN: begin
               if (!muteReq_r) ramp_r <= AMD_UP;
               else if (step_r == `AMD_RAMP_STEPS) ramp_r <= AMD_MUTED;
            end
            AMD_MUTED:   if (!muteReq_r) ramp_r <= AMD_UP;
            AMD_UP: begin
               if (muteReq_r) ramp_r <= AMD_DOWN;
               else if (step_r == 6'd0) ramp_r <= AMD_UNMUTED;
            end
            default:     ramp_r <= AMD_UNMUTED;
         endcase
      end
   end

   // One 1.5 dB step every speedEff samples in either direction.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         step_r   <= 6'd0;
         spdCnt_r <= 5'd0;
      end else if (strobe) begin
         spdCnt_r <= tick ? 5'd0 : spdCnt_r + 5'd1;
         if (tick && ramp_r == AMD_DOWN && step_r != `AMD_RAMP_STEPS) step_r <= step_r + 6'd1;
         if (tick && ramp_r == AMD_UP && step_r != 6'd0) step_r <= step_r - 6'd1;
      end
   end

   // Path changes only at full mute, so no click escapes the switch.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) bypassEff_r <= 1'b0;
      else if (ramp_r == AMD_MUTED) begin
         bypassEff_r <= manSel_r ? bypassBit_r : multiFlag_r;
      end
   end

   // ----------------------------------------------------------------
   // Delay line
   // ----------------------------------------------------------------
   // Reading the slot before it is overwritten gives exactly one lap of delay.
   always_ff @(posedge mclk) begin
      if (strobe) dlMem[dlPtr_r] <= sampleIn;
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         dlPtr_r  <= 9'd0;
         dlData_r <= '0;
         direct_r <= '0;
         pkt_r    <= '{kind: AMD_PKT_OTHER, compressed: 1'b0, layout: 1'b0};
      end else if (strobe) begin
         dlPtr_r  <= dlPtr_r + 9'd1;
         dlData_r <= dlMem[dlPtr_r];
         direct_r <= sampleIn;
         pkt_r    <= pktInfo;
      end
   end
   assign src = bypassEff_r ? direct_r : dlData_r;

   // ----------------------------------------------------------------
   // Ramped mute output
   // ----------------------------------------------------------------
   // Gain is a quarter-6 dB fraction then a shift; past the last step it is zero.
   function automatic logic [23:0] amd_gain(input logic [23:0] x, input logic [5:0] st);
      logic signed [33:0] prod;
      logic        [8:0]  frac;
      case (st[1:0])
         2'd0:    frac = 9'h100;
         2'd1:    frac = 9'h0d7;
         2'd2:    frac = 9'h0b5;
         default: frac = 9'h099;
      endcase
      prod = $signed(x) * $signed({1'b0, frac});
      prod = prod >>> (5'd8 + {1'b0, st[5:2]});
      return (st >= `AMD_RAMP_STEPS) ? 24'h00_0000 : prod[23:0];
   endfunction

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sampleOut      <= '0;
         sampleOutValid <= 1'b0;
      end else begin
         sampleOutValid <= strobeD_r;
         if (strobeD_r) begin
            if (pkt_r.compressed && muteReq_r) sampleOut <= '0;
            else if (pkt_r.kind == AMD_PKT_SAMPLE && !pkt_r.compressed) begin
               sampleOut.left  <= amd_gain(src.left, step_r);
               sampleOut.right <= amd_gain(src.right, step_r);
            end else sampleOut <= src;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_setup;
      psel && !penable && !pwrite;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence

   property p_mclk_ratio;
      @(posedge mclk) disable iff (reset)
      !$past(reset) |-> audioMasterClockOutRatio == ({7'd0, $past(mult_r)} + 10'd1) * 10'd128;
   endproperty
   a_mclk_ratio: assert property (p_mclk_ratio) else $error("master clock ratio wrong");

   property p_mult_valid;
      @(posedge mclk) disable iff (reset) mult_r <= 3'h5;
   endproperty
   a_mult_valid: assert property (p_mult_valid) else $error("invalid clock multiple held");

   property p_layout;
      @(posedge mclk) disable iff (reset)
      strobe && pktInfo.kind == AMD_PKT_SAMPLE |=> layoutRaw_r == !$past(pktInfo.layout);
   endproperty
   a_layout: assert property (p_layout) else $error("layout status not inverted");

   property p_cond_mute;
      @(posedge mclk) disable iff (reset) condActive |=> muteReq_r;
   endproperty
   a_cond_mute: assert property (p_cond_mute) else $error("condition did not mute");

   property p_force;
      @(posedge mclk) disable iff (reset) force_r |=> muteReq_r && muteOut;
   endproperty
   a_force: assert property (p_force) else $error("force mute not held");

   property p_hold_manual;
      @(posedge mclk) disable iff (reset) muteReq_r && noAuto_r |=> muteReq_r;
   endproperty
   a_hold_manual: assert property (p_hold_manual) else $error("unmuted with auto disabled");

   property p_zero_compressed;
      @(posedge mclk) disable iff (reset)
      strobeD_r && pkt_r.compressed && muteReq_r |=> sampleOut == '0 && sampleOutValid;
   endproperty
   a_zero_compressed: assert property (p_zero_compressed) else $error("compressed mute not zero");

   property p_step_range;
      @(posedge mclk) disable iff (reset)
      step_r <= `AMD_RAMP_STEPS && (step_r == $past(step_r) || step_r == $past(step_r) + 6'd1
                                    || step_r == $past(step_r) - 6'd1);
   endproperty
   a_step_range: assert property (p_step_range) else $error("ramp step jumped");

   property p_unmapped;
      @(posedge mclk) disable iff (reset) s_setup ##0 (!addrOk) |=> s_access ##0 pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read gave no error");
endmodule

// *** rtl/amd_params.svh ***
// Purpose: Constants for the audio mute and delay control block.
// Assumes: 25 MHz register clock, APB register access, word-aligned registers.
// Notes:   Byte address of each register is four times its index.
`ifndef AMD_PARAMS_SVH
`define AMD_PARAMS_SVH
// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define AMD_ADDR_CHMODE   ({8'h07, 2'b00})
`define AMD_ADDR_DELAY    ({8'h0f, 2'b00})
`define AMD_ADDR_MASK     ({8'h14, 2'b00})
`define AMD_ADDR_MUTE     ({8'h1a, 2'b00})
`define AMD_ADDR_STATUS   ({8'h65, 2'b00})
`define AMD_ADDR_MCLK     ({8'hb5, 2'b00})
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define AMD_BIT_MULTI     6
`define AMD_BIT_MANSEL    7
`define AMD_BIT_BYPASS    6
`define AMD_BIT_FORCE     4
`define AMD_BIT_NOAUTO    0
`define AMD_BIT_LAYOUT    4
`define AMD_BIT_INTMUTE   6
`define AMD_RST_MULT      3'h1
`define AMD_MAX_MULT      3'h5
`define AMD_RST_SPEED     5'h1f
`define AMD_RST_MASK      8'hff
`define AMD_MCLK_BASE     10'd128
// ----------------------------------------------------------------
// Stream and timing constants
// ----------------------------------------------------------------
`define AMD_DL_DEPTH      512
`define AMD_RAMP_STEPS    6'd32
`define AMD_CLK_NS        40
`define AMD_MS_NS         1000000
`define AMD_MS_CYCLES     (`AMD_MS_NS / `AMD_CLK_NS)
`define AMD_WAIT_MS_1     10'd10
`define AMD_WAIT_MS_2     10'd25
`define AMD_WAIT_MS_3     10'd50
`define AMD_WAIT_MS_4     10'd75
`define AMD_WAIT_MS_5     10'd100
`define AMD_WAIT_MS_6     10'd250
`define AMD_WAIT_MS_7     10'd1000
`endif

// *** rtl/amd_pkg.sv ***
// Purpose: Types shared by the audio mute and delay control block.
// Assumes: Samples are 24-bit two's complement, two channels.
// Notes:   Constants live in amd_params.svh.
package amd_pkg;
   // ----------------------------------------------------------------
   // Stream carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [23:0] left;
      logic [23:0] right;
   } amd_sample_s;

   typedef enum logic [1:0] {
      AMD_PKT_SAMPLE = 2'b00,
      AMD_PKT_ONEBIT = 2'b01,
      AMD_PKT_OTHER  = 2'b10
   } amd_pkt_e;

   typedef struct packed {
      amd_pkt_e kind;
      logic     compressed;
      logic     layout;
   } amd_pkt_s;

   typedef enum logic [1:0] {
      AMD_UNMUTED = 2'b00,
      AMD_DOWN    = 2'b01,
      AMD_MUTED   = 2'b10,
      AMD_UP      = 2'b11
   } amd_ramp_e;
endpackage

// *** verification/amd_backend_model.sv ***
// Purpose: Back-end audio processor that takes the conditioned stream.
// Assumes: One valid pulse per sample on the register clock.
// Notes:   Keeps only the newest sample and a running count.
`timescale 1ns/1ns
module amd_backend_model
   import amd_pkg::*;
(
   input  wire logic        mclk,           // Register clock.
   input  wire logic        reset,          // Asynchronous reset, active high.
   input  wire amd_sample_s sampleOut,      // Conditioned sample.
   input  wire logic        sampleOutValid, // Marks a new sample.
   output amd_sample_s      lastSample,     // Newest sample taken.
   output logic      [15:0] sampleCount     // Samples taken so far.
);
   // --------------------------------------
   // Sample capture
   // --------------------------------------
   // Latch each sample as the serial port of the back end would.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         lastSample  <= '0;
         sampleCount <= 16'h0000;
      end else if (sampleOutValid) begin
         lastSample  <= sampleOut;
         sampleCount <= sampleCount + 16'h0001;
      end
   end
endmodule

// *** verification/tb.sv ***
// Purpose: Self-checking bench for the audio mute and delay block.
// Assumes: A sample every 320 ns; one millisecond shortened to 10 cycles.
// Notes:   Sample data moves late in each period, clear of its capture.
`timescale 1ns/1ns
`include "amd_params.svh"
module tb;
   import amd_pkg::*;
   logic        mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic        pready, pslverr, er, sampleOutValid, muteOut, coastOut, sampleClk = 0;
   logic [9:0]  paddr = '0, ratio;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [7:0]  muteEvents = '0;
   logic [23:0] idx = '0;
   logic [2:0]  ph = '0;
   logic [15:0] sampleCount;
   amd_sample_s sampleIn = '0, sampleOut, lastSample;
   amd_pkt_s    pktInfo = 4'h1, pktReq = 4'h1;
   int          errors = 0, tests_run = 0;
   // --------------------------------------
   // Clocks, sample source and parts
   // --------------------------------------
   // Register clock, 25 MHz.
   always #20 mclk = ~mclk;
   // Sample clock of eight register clocks; data moves one cycle before each rise, far from its capture.
   always @(posedge mclk) begin
      ph <= ph + 3'd1;
      sampleClk <= (ph < 3'd4);
      if (ph == 3'd7) begin
         idx <= idx + 24'h1;
         sampleIn <= smp(idx + 24'h1);
         pktInfo <= pktReq;
      end
   end
   amd_mute_delay #(.MS_CYCLES(10)) i_dut (.mclk, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .sampleClk, .sampleIn, .pktInfo, .muteEvents,
      .sampleOut, .sampleOutValid, .muteOut, .coastOut, .audioMasterClockOutRatio(ratio));
   amd_backend_model i_back (.mclk, .reset, .sampleOut, .sampleOutValid, .lastSample,
      .sampleCount);
   // --------------------------------------
   // Shared tasks
   // --------------------------------------
   function automatic amd_sample_s smp(logic [23:0] v);
      smp = {v, ~v};
   endfunction
   task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(logic w, logic [9:0] a, logic [31:0] d);
      @(posedge mclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic smp_wait(int k);
      logic [15:0] t;
      repeat (k) begin
         t = sampleCount;
         while (sampleCount === t) @(posedge mclk);
      end
   endtask
   task automatic pkt_read(amd_pkt_s p, logic [9:0] a);
      pktReq = p;
      smp_wait(3);
      apb(0, a, 0);
   endtask
   // --------------------------------------
   // Scenarios
   // --------------------------------------
   task automatic t_delay();
      smp_wait(520);
      chk("delayed sample", smp(idx - 24'd512), lastSample);
   endtask
   task automatic t_clock();
      apb(0, `AMD_ADDR_MCLK, 0);
      chk("clock multiple", 1, rd);
      chk("clock ratio", 256, ratio);
      for (int c = 0; c < 8; c++) begin
         apb(1, `AMD_ADDR_MCLK, c);
         repeat (2) @(posedge mclk);
         chk("clock ratio", (c > 5 ? 6 : c + 1) * 128, ratio);
      end
      apb(0, `AMD_ADDR_MCLK, 0);
      chk("clock multiple", 5, rd);
      chk("pready", 1, pready);
      apb(0, 10'h3fc, 0);
      chk("unmapped error", 1, er);
   endtask
   task automatic t_layout();
      pkt_read(4'h0, `AMD_ADDR_STATUS);
      chk("layout status", 1, rd[4]);
      apb(0, `AMD_ADDR_CHMODE, 0);
      chk("multichannel flag", 1, rd[6]);
      pkt_read(4'h9, `AMD_ADDR_STATUS);
      chk("layout status", 1, rd[4]);
      pkt_read(4'h1, `AMD_ADDR_STATUS);
      chk("layout status", 0, rd[4]);
      pkt_read(4'h4, `AMD_ADDR_STATUS);
      chk("layout status", 1, rd[4]);
      pktReq = 4'h1;
   endtask
   task automatic t_events();
      apb(1, `AMD_ADDR_MUTE, 32'h01);
      muteEvents <= 8'h01;
      repeat (5) @(posedge mclk);
      chk("coastOut", 1, coastOut);
      chk("muteOut", 1, muteOut);
      muteEvents <= 8'h00;
      repeat (30) @(posedge mclk);
      chk("muteOut", 1, muteOut);
      apb(1, `AMD_ADDR_MUTE, 32'h00);
      repeat (2) @(posedge mclk);
      chk("muteOut", 0, muteOut);
      apb(1, `AMD_ADDR_MUTE, 32'h02);
      muteEvents <= 8'h01;
      repeat (5) @(posedge mclk);
      muteEvents <= 8'h00;
      repeat (90) @(posedge mclk);
      chk("muteOut", 1, muteOut);
      repeat (20) @(posedge mclk);
      chk("muteOut", 0, muteOut);
   endtask
   task automatic t_bypass();
      apb(1, `AMD_ADDR_MASK, 0);
      apb(1, `AMD_ADDR_DELAY, 32'hc1);
      apb(1, `AMD_ADDR_MUTE, 32'h10);
      repeat (2) @(posedge mclk);
      chk("muteOut", 1, muteOut);
      smp_wait(2);
      chk("ramp start", 1, lastSample != 0);
      smp_wait(40);
      chk("ramp end", 0, lastSample);
      apb(1, `AMD_ADDR_MUTE, 0);
      repeat (2) @(posedge mclk);
      chk("muteOut", 0, muteOut);
      smp_wait(40);
      chk("bypassed sample", smp(idx), lastSample);
      pktReq = 4'h3;
      smp_wait(2);
      apb(1, `AMD_ADDR_MUTE, 32'h10);
      smp_wait(2);
      chk("compressed mute", 0, lastSample);
   endtask
   // --------------------------------------
   // Run control
   // --------------------------------------
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Hangs are cut off well beyond the expected run of about 210 us.
   initial begin
      #1000000;
      errors++;
      finish_test();
   end
   initial begin
      repeat (2) @(posedge mclk);
      reset <= 0;
      t_delay();
      t_clock();
      t_layout();
      t_events();
      t_bypass();
      finish_test();
   end
endmodule
